/* File: verilog/clrc_pkg.sv */
// Shared constants and types for the compare, loop and return control unit
package clrc_pkg;

   typedef enum logic [3:0] {
      OP_CMPB_A    = 4'h0,
      OP_CMPW_A    = 4'h1,
      OP_CMPB_EA   = 4'h2,
      OP_CMPW_EA   = 4'h3,
      OP_DECB      = 4'h4,
      OP_DECW      = 4'h5,
      OP_TRAP_V8   = 4'h6,
      OP_TRAP_A16  = 4'h7,
      OP_TRAP_FAR  = 4'h8,
      OP_TRAP_NINE = 4'h9,
      OP_IRQ_EXIT  = 4'ha,
      OP_FAST_EXIT = 4'hb,
      OP_FRAME_SET = 4'hc,
      OP_FRAME_TD  = 4'hd,
      OP_SUB_WORD  = 4'he,
      OP_SUB_FAR   = 4'hf
   } clrc_op_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_MEM  = 2'b01,
      ST_CAP  = 2'b10,
      ST_WAIT = 2'b11
   } clrc_state_t;

   // Status word layout
   localparam int PS_I_BIT = 6;
   localparam int PS_S_BIT = 5;
   localparam int PS_N_BIT = 3;
   localparam int PS_Z_BIT = 2;
   localparam int PS_V_BIT = 1;
   localparam int PS_C_BIT = 0;

   // Branch timing classes, taken and not taken
   localparam logic [7:0] CYC_CLS1_TK  = 8'h04;
   localparam logic [7:0] CYC_CLS1_NT  = 8'h03;
   localparam logic [7:0] CYC_CLS2_TK  = 8'h05;
   localparam logic [7:0] CYC_CLS2_NT  = 8'h04;
   localparam logic [7:0] CYC_MEM1_TK  = 8'h05;
   localparam logic [7:0] CYC_MEM1_NT  = 8'h04;
   localparam logic [7:0] CYC_MEM2_TK  = 8'h06;
   localparam logic [7:0] CYC_MEM2_NT  = 8'h05;

   // Fixed counts of trap, return and frame forms
   localparam logic [7:0] CYC_TRAP_V8  = 8'h0d;
   localparam logic [7:0] CYC_TRAP_A16 = 8'h0e;
   localparam logic [7:0] CYC_TRAP_FAR = 8'h09;
   localparam logic [7:0] CYC_TRAP_NIN = 8'h0b;
   localparam logic [7:0] CYC_IRQ_EXIT = 8'h0b;
   localparam logic [7:0] CYC_FAST_EX  = 8'h06;
   localparam logic [7:0] CYC_FRAME_S  = 8'h06;
   localparam logic [7:0] CYC_FRAME_T  = 8'h05;
   localparam logic [7:0] CYC_SUB_WORD = 8'h04;
   localparam logic [7:0] CYC_SUB_FAR  = 8'h05;

   // Fast exit corrections: three byte plus two word, or six word
   localparam logic [7:0] FAST_B_MUL   = 8'h03;
   localparam logic [7:0] FAST_C_MUL   = 8'h02;
   localparam logic [7:0] FAST_RET_MUL = 8'h06;

   // Stack words moved by the context save and restore
   localparam logic [1:0] CTX_WORDS    = 2'd3;
   localparam logic [15:0] WORD_STEP   = 16'h0002;

   localparam logic [15:0] PS_RST      = 16'h0000;

endpackage

/* File: verilog/clrc_alu.sv */
// Compare and decrement arithmetic with flag generation
`timescale 1ns/100ps
module clrc_alu
   import clrc_pkg::*;
(
   input  wire logic        word_i,
   input  wire logic        dec_i,
   input  wire logic [15:0] opnd_i,
   input  wire logic [15:0] imm_i,
   output logic      [15:0] result_o,
   output logic             ne_o,
   output logic             n_o,
   output logic             z_o,
   output logic             v_o,
   output logic             c_o
);

   logic [16:0] diff;
   logic [15:0] subtr;
   logic [15:0] a;
   logic        sa;
   logic        sb;
   logic        sr;

   always_comb begin
      a      = word_i ? opnd_i : {8'h00, opnd_i[7:0]};
      subtr  = dec_i ? 16'h0001 : (word_i ? imm_i : {8'h00, imm_i[7:0]});
      diff   = {1'b0, a} - {1'b0, subtr};
      result_o = word_i ? diff[15:0] : {8'h00, diff[7:0]};
      sa     = word_i ? a[15] : a[7];
      sb     = word_i ? subtr[15] : subtr[7];
      sr     = word_i ? diff[15] : diff[7];
      n_o    = sr;
      z_o    = word_i ? (diff[15:0] == 16'h0000) : (diff[7:0] == 8'h00);
      // Signed overflow of a subtraction
      v_o    = (sa ^ sb) & (sa ^ sr);
      // Borrow out of the operand width
      c_o    = word_i ? diff[16] : (a[7:0] < subtr[7:0]);
      ne_o   = ~z_o;
   end

endmodule

/* File: verilog/clrc_exec.sv */
// Execution sequencer for compare-branch, loop, trap, frame and return forms
`timescale 1ns/100ps
// Functional notes
// RL1 - Byte compare of accumulator with imm8, branch if unequal, set NZVC
// RL2 - Word compare of accumulator with imm16, branch if unequal, set NZVC
// RL3 - Byte compare of register or memory with imm8, branch if unequal, NZVC
// RL4 - Word compare of register or memory with imm16, branch if unequal, NZVC
// RL5 - Byte decrement, write back, branch if nonzero; NZV updated, C kept
// RL6 - Word decrement, branch if nonzero; memory form is read-modify-write (here only the write is issued, the operand comes in on OPND_I)
// RL7 - Base timing class: four cycles taken, three not taken
// RL8 - Second timing class: five cycles taken, four not taken
// RL9 - Memory forms: 5/4 or 6/5 cycles plus addressing correction
// RL10 - Fast exit: 3 byte plus 2 word corrections on request, else six word
// RL11 - Fast exit with pending request jumps to vector, no unstack or restack
// RL12 - Frame setup pushes frame pointer, reloads it, reserves imm8 local area
// RL13 - Frame teardown restores frame pointer, frees locals, flags unchanged
// RL14 - Short return pops one word into program counter, flags unchanged
// RL15 - Far return pops long word into counter and bank, flags unchanged
// RL16 - Traps clear I and set S; interrupt exit restores flags from stack
module clrc_exec
   import clrc_pkg::*;
(
   input  wire logic        REF_CLK_I,
   input  wire logic        RSTN_I,
   input  wire logic        START_I,
   input  wire logic [3:0]  OP_I,
   input  wire logic        MEM_FORM_I,
   input  wire logic [15:0] OPND_I,
   input  wire logic [15:0] IMM_I,
   input  wire logic [7:0]  REL_I,
   input  wire logic [15:0] EA_I,
   input  wire logic [15:0] PC_I,
   input  wire logic [7:0]  PCB_I,
   input  wire logic [15:0] SP_I,
   input  wire logic [15:0] FP_I,
   input  wire logic [15:0] PS_I,
   input  wire logic [23:0] VECTOR_I,
   input  wire logic        IRQ_PEND_I,
   input  wire logic [3:0]  CORR_A_I,
   input  wire logic [3:0]  CORR_B_I,
   input  wire logic [3:0]  CORR_C_I,
   input  wire logic [3:0]  CORR_D_I,
   input  wire logic [15:0] MEM_RDATA_I,
   output logic             BUSY_O,
   output logic             DONE_O,
   output logic             TAKEN_O,
   output logic      [15:0] PC_O,
   output logic      [7:0]  PCB_O,
   output logic      [15:0] SP_O,
   output logic      [15:0] FP_O,
   output logic      [15:0] PS_O,
   output logic             REG_WE_O,
   output logic      [15:0] REG_WDATA_O,
   output logic             MEM_REQ_O,
   output logic             MEM_WR_O,
   output logic             MEM_BYTE_O,
   output logic      [15:0] MEM_ADDR_O,
   output logic      [15:0] MEM_WDATA_O
);

   clrc_op_t    op;
   clrc_state_t state_r, state_nxt;
   clrc_op_t    op_r, op_nxt;
   logic [7:0]  total_r, total_nxt;
   logic [7:0]  cnt_r, cnt_nxt;
   logic [1:0]  steps_r, steps_nxt;
   logic [1:0]  step_r, step_nxt;
   logic        taken_r, taken_nxt;
   logic        wide_r, wide_nxt;
   logic [15:0] res_r, res_nxt;
   logic [15:0] ea_r, ea_nxt;
   logic [15:0] sp_r, sp_nxt;
   logic [15:0] fp_r, fp_nxt;
   logic [15:0] ps_r, ps_nxt;
   logic [15:0] pc_r, pc_nxt;
   logic [7:0]  pcb_r, pcb_nxt;
   logic [15:0] pop_r [3];
   logic [15:0] pop_nxt [3];
   logic        busy_r, busy_nxt;
   logic        done_r, done_nxt;
   logic        tk_o_r, tk_o_nxt;
   logic [15:0] pc_o_r, pc_o_nxt;
   logic [7:0]  pcb_o_r, pcb_o_nxt;
   logic [15:0] sp_o_r, sp_o_nxt;
   logic [15:0] fp_o_r, fp_o_nxt;
   logic [15:0] ps_o_r, ps_o_nxt;
   logic        rwe_r, rwe_nxt;
   logic [15:0] rwd_r, rwd_nxt;
   logic        mreq_r, mreq_nxt;
   logic        mwr_r, mwr_nxt;
   logic        mbyte_r, mbyte_nxt;
   logic [15:0] maddr_r, maddr_nxt;
   logic [15:0] mwdata_r, mwdata_nxt;

   logic        alu_word;
   logic        alu_dec;
   logic [15:0] alu_res;
   logic        alu_ne;
   logic        alu_n;
   logic        alu_z;
   logic        alu_v;
   logic        alu_c;
   logic [15:0] target;

   function automatic logic [7:0] mul4(input logic [7:0] k, input logic [3:0] c);
      mul4 = 8'(k * {4'h0, c});
   endfunction

   function automatic logic [7:0] pick(input logic tk, input logic [7:0] t,
                                       input logic [7:0] n);
      pick = tk ? t : n;
   endfunction

   assign op       = clrc_op_t'(OP_I);
   assign alu_word = (op == OP_CMPW_A) || (op == OP_CMPW_EA) || (op == OP_DECW);
   assign alu_dec  = (op == OP_DECB) || (op == OP_DECW);
   assign target   = PC_I + {{8{REL_I[7]}}, REL_I};

   clrc_alu u_alu (
      .word_i   (alu_word),
      .dec_i    (alu_dec),
      .opnd_i   (OPND_I),
      .imm_i    (IMM_I),
      .result_o (alu_res),
      .ne_o     (alu_ne),
      .n_o      (alu_n),
      .z_o      (alu_z),
      .v_o      (alu_v),
      .c_o      (alu_c)
   );

   always_comb begin
      state_nxt  = state_r;
      op_nxt     = op_r;
      total_nxt  = total_r;
      cnt_nxt    = cnt_r + 8'h01;
      steps_nxt  = steps_r;
      step_nxt   = step_r;
      taken_nxt  = taken_r;
      wide_nxt   = wide_r;
      res_nxt    = res_r;
      ea_nxt     = ea_r;
      sp_nxt     = sp_r;
      fp_nxt     = fp_r;
      ps_nxt     = ps_r;
      pc_nxt     = pc_r;
      pcb_nxt    = pcb_r;
      pop_nxt    = pop_r;
      busy_nxt   = busy_r;
      done_nxt   = 1'b0;
      tk_o_nxt   = tk_o_r;
      pc_o_nxt   = pc_o_r;
      pcb_o_nxt  = pcb_o_r;
      sp_o_nxt   = sp_o_r;
      fp_o_nxt   = fp_o_r;
      ps_o_nxt   = ps_o_r;
      rwe_nxt    = 1'b0;
      rwd_nxt    = rwd_r;
      mreq_nxt   = 1'b0;
      mwr_nxt    = 1'b0;
      mbyte_nxt  = 1'b0;
      maddr_nxt  = maddr_r;
      mwdata_nxt = mwdata_r;
      unique case (state_r)
         ST_IDLE: begin
            cnt_nxt = 8'h01;
            if (START_I) begin
               op_nxt    = op;
               busy_nxt  = 1'b1;
               ea_nxt    = EA_I;
               sp_nxt    = SP_I;
               fp_nxt    = FP_I;
               ps_nxt    = PS_I;
               pc_nxt    = PC_I;
               pcb_nxt   = PCB_I;
               res_nxt   = alu_res;
               wide_nxt  = alu_word;
               taken_nxt = 1'b0;
               steps_nxt = 2'd0;
               step_nxt  = 2'd0;
               state_nxt = ST_WAIT;
               unique case (op)
                  OP_CMPB_A, OP_CMPW_A, OP_CMPB_EA, OP_CMPW_EA: begin
                     taken_nxt           = alu_ne; // [RL1] [RL2] [RL3] [RL4]
                     ps_nxt[PS_N_BIT]    = alu_n;
                     ps_nxt[PS_Z_BIT]    = alu_z;
                     ps_nxt[PS_V_BIT]    = alu_v;
                     ps_nxt[PS_C_BIT]    = alu_c;
                     if (alu_ne) begin
                        pc_nxt = target;
                     end
                     if (op == OP_CMPB_A || op == OP_CMPW_A) begin
                        total_nxt = pick(alu_ne, CYC_CLS1_TK, CYC_CLS1_NT); // [RL7]
                     end else if (!MEM_FORM_I) begin
                        total_nxt = (op == OP_CMPB_EA) ?
                                    pick(alu_ne, CYC_CLS1_TK, CYC_CLS1_NT) : // [RL7]
                                    pick(alu_ne, CYC_CLS2_TK, CYC_CLS2_NT); // [RL8]
                     end else if (op == OP_CMPB_EA) begin
                        total_nxt = pick(alu_ne, CYC_MEM1_TK, CYC_MEM1_NT)
                                    + {4'h0, CORR_A_I} + {4'h0, CORR_B_I}; // [RL9]
                     end else begin
                        total_nxt = pick(alu_ne, CYC_MEM2_TK, CYC_MEM2_NT)
                                    + {4'h0, CORR_A_I} + {4'h0, CORR_C_I}; // [RL9]
                     end
                  end
                  OP_DECB, OP_DECW: begin
                     taken_nxt        = ~alu_z; // [RL5] [RL6]
                     ps_nxt[PS_N_BIT] = alu_n;
                     ps_nxt[PS_Z_BIT] = alu_z;
                     ps_nxt[PS_V_BIT] = alu_v; // [RL5]
                     if (!alu_z) begin
                        pc_nxt = target;
                     end
                     if (MEM_FORM_I) begin
                        steps_nxt = 2'd1; // [RL6]
                        state_nxt = ST_MEM;
                        total_nxt = pick(~alu_z, CYC_MEM2_TK, CYC_MEM2_NT)
                                    + {4'h0, CORR_A_I}
                                    + mul4(8'h02, alu_word ? CORR_C_I : CORR_B_I); // [RL9]
                     end else begin
                        rwe_nxt   = 1'b1;
                        rwd_nxt   = alu_res; // [RL5]
                        total_nxt = pick(~alu_z, CYC_CLS2_TK, CYC_CLS2_NT); // [RL8]
                     end
                  end
                  OP_TRAP_V8, OP_TRAP_A16, OP_TRAP_FAR, OP_TRAP_NINE: begin
                     steps_nxt        = CTX_WORDS;
                     state_nxt        = ST_MEM;
                     taken_nxt        = 1'b1;
                     // Old context stays latched for the pushes, vector parked
                     ea_nxt           = VECTOR_I[15:0];
                     res_nxt          = {8'h00, VECTOR_I[23:16]};
                     unique case (op)
                        OP_TRAP_V8:  total_nxt = CYC_TRAP_V8;
                        OP_TRAP_A16: total_nxt = CYC_TRAP_A16;
                        OP_TRAP_FAR: total_nxt = CYC_TRAP_FAR;
                        default:     total_nxt = CYC_TRAP_NIN;
                     endcase
                     total_nxt = total_nxt + mul4(8'h08, CORR_C_I);
                  end
                  OP_IRQ_EXIT: begin
                     steps_nxt = CTX_WORDS;
                     state_nxt = ST_MEM;
                     taken_nxt = 1'b1;
                     total_nxt = CYC_IRQ_EXIT + mul4(FAST_RET_MUL, CORR_C_I);
                  end
                  OP_FAST_EXIT: begin
                     taken_nxt = 1'b1;
                     if (IRQ_PEND_I) begin
                        pc_nxt    = VECTOR_I[15:0]; // [RL11]
                        pcb_nxt   = VECTOR_I[23:16];
                        total_nxt = CYC_FAST_EX + mul4(FAST_B_MUL, CORR_B_I)
                                    + mul4(FAST_C_MUL, CORR_C_I); // [RL10]
                     end else begin
                        steps_nxt = CTX_WORDS;
                        state_nxt = ST_MEM;
                        total_nxt = CYC_FAST_EX + mul4(FAST_RET_MUL, CORR_C_I); // [RL10]
                     end
                  end
                  OP_FRAME_SET: begin
                     steps_nxt = 2'd1;
                     state_nxt = ST_MEM;
                     res_nxt   = FP_I; // [RL12]
                     fp_nxt    = SP_I - WORD_STEP; // [RL12]
                     sp_nxt    = SP_I - WORD_STEP - {8'h00, IMM_I[7:0]}; // [RL12]
                     total_nxt = CYC_FRAME_S + {4'h0, CORR_C_I};
                  end
                  OP_FRAME_TD: begin
                     steps_nxt = 2'd1;
                     state_nxt = ST_MEM;
                     sp_nxt    = FP_I + WORD_STEP; // [RL13]
                     total_nxt = CYC_FRAME_T + {4'h0, CORR_C_I};
                  end
                  OP_SUB_WORD: begin
                     steps_nxt = 2'd1;
                     state_nxt = ST_MEM;
                     taken_nxt = 1'b1;
                     sp_nxt    = SP_I + WORD_STEP; // [RL14]
                     total_nxt = CYC_SUB_WORD + {4'h0, CORR_C_I};
                  end
                  OP_SUB_FAR: begin
                     steps_nxt = 2'd2;
                     state_nxt = ST_MEM;
                     taken_nxt = 1'b1;
                     sp_nxt    = SP_I + WORD_STEP + WORD_STEP; // [RL15]
                     total_nxt = CYC_SUB_FAR + {4'h0, CORR_D_I};
                  end
               endcase
            end
         end
         ST_MEM: begin
            mreq_nxt  = 1'b1;
            state_nxt = ST_CAP;
            unique case (op_r)
               OP_DECB, OP_DECW: begin
                  mwr_nxt    = 1'b1; // [RL6]
                  mbyte_nxt  = ~wide_r;
                  maddr_nxt  = ea_r;
                  mwdata_nxt = res_r;
               end
               OP_TRAP_V8, OP_TRAP_A16, OP_TRAP_FAR, OP_TRAP_NINE: begin
                  mwr_nxt   = 1'b1;
                  maddr_nxt = sp_r - 16'({step_r, 1'b0} + 3'd2);
                  unique case (step_r)
                     2'd0:    mwdata_nxt = ps_r;
                     2'd1:    mwdata_nxt = {8'h00, pcb_r};
                     default: mwdata_nxt = pc_r;
                  endcase
               end
               OP_FRAME_SET: begin
                  mwr_nxt    = 1'b1;
                  maddr_nxt  = fp_r;
                  mwdata_nxt = res_r;
               end
               OP_FRAME_TD: begin
                  maddr_nxt = sp_r - WORD_STEP;
               end
               OP_SUB_WORD, OP_SUB_FAR: begin
                  maddr_nxt = sp_r - 16'({steps_r - step_r, 1'b0});
               end
               default: begin
                  maddr_nxt = sp_r + 16'({step_r, 1'b0});
               end
            endcase
         end
         ST_CAP: begin
            if (!mwr_r) begin
               pop_nxt[step_r] = MEM_RDATA_I;
            end
            step_nxt  = step_r + 2'd1;
            state_nxt = (step_r + 2'd1 == steps_r) ? ST_WAIT : ST_MEM;
         end
         ST_WAIT: begin
            if (cnt_r >= total_r) begin
               state_nxt = ST_IDLE;
               busy_nxt  = 1'b0;
               done_nxt  = 1'b1;
               tk_o_nxt  = taken_r;
               pc_o_nxt  = pc_r;
               pcb_o_nxt = pcb_r;
               sp_o_nxt  = sp_r;
               fp_o_nxt  = fp_r;
               ps_o_nxt  = ps_r;
               unique case (op_r)
                  OP_IRQ_EXIT: begin
                     pc_o_nxt  = pop_r[0];
                     pcb_o_nxt = pop_r[1][7:0];
                     ps_o_nxt  = pop_r[2]; // [RL16]
                     sp_o_nxt  = sp_r + 16'({CTX_WORDS, 1'b0});
                  end
                  OP_FAST_EXIT: begin
                     if (steps_r != 2'd0) begin
                        pc_o_nxt  = pop_r[0];
                        pcb_o_nxt = pop_r[1][7:0];
                        ps_o_nxt  = pop_r[2];
                        sp_o_nxt  = sp_r + 16'({CTX_WORDS, 1'b0});
                     end
                  end
                  OP_TRAP_V8, OP_TRAP_A16, OP_TRAP_FAR, OP_TRAP_NINE: begin
                     sp_o_nxt  = sp_r - 16'({CTX_WORDS, 1'b0});
                     pc_o_nxt  = ea_r;
                     pcb_o_nxt = res_r[7:0];
                     ps_o_nxt[PS_I_BIT] = 1'b0; // [RL16]
                     ps_o_nxt[PS_S_BIT] = 1'b1; // [RL16]
                  end
                  OP_FRAME_TD: fp_o_nxt = pop_r[0]; // [RL13]
                  OP_SUB_WORD: pc_o_nxt = pop_r[0]; // [RL14]
                  OP_SUB_FAR: begin
                     pc_o_nxt  = pop_r[0]; // [RL15]
                     pcb_o_nxt = pop_r[1][7:0];
                  end
                  default: ;
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I) begin
         state_r  <= ST_IDLE;
         op_r     <= OP_CMPB_A;
         total_r  <= 8'h00;
         cnt_r    <= 8'h00;
         steps_r  <= 2'd0;
         step_r   <= 2'd0;
         taken_r  <= 1'b0;
         wide_r   <= 1'b0;
         res_r    <= 16'h0000;
         ea_r     <= 16'h0000;
         sp_r     <= 16'h0000;
         fp_r     <= 16'h0000;
         ps_r     <= PS_RST;
         pc_r     <= 16'h0000;
         pcb_r    <= 8'h00;
         pop_r    <= '{16'h0000, 16'h0000, 16'h0000};
         busy_r   <= 1'b0;
         done_r   <= 1'b0;
         tk_o_r   <= 1'b0;
         pc_o_r   <= 16'h0000;
         pcb_o_r  <= 8'h00;
         sp_o_r   <= 16'h0000;
         fp_o_r   <= 16'h0000;
         ps_o_r   <= PS_RST;
         rwe_r    <= 1'b0;
         rwd_r    <= 16'h0000;
         mreq_r   <= 1'b0;
         mwr_r    <= 1'b0;
         mbyte_r  <= 1'b0;
         maddr_r  <= 16'h0000;
         mwdata_r <= 16'h0000;
      end else begin
         state_r  <= state_nxt;
         op_r     <= op_nxt;
         total_r  <= total_nxt;
         cnt_r    <= cnt_nxt;
         steps_r  <= steps_nxt;
         step_r   <= step_nxt;
         taken_r  <= taken_nxt;
         wide_r   <= wide_nxt;
         res_r    <= res_nxt;
         ea_r     <= ea_nxt;
         sp_r     <= sp_nxt;
         fp_r     <= fp_nxt;
         ps_r     <= ps_nxt;
         pc_r     <= pc_nxt;
         pcb_r    <= pcb_nxt;
         pop_r    <= pop_nxt;
         busy_r   <= busy_nxt;
         done_r   <= done_nxt;
         tk_o_r   <= tk_o_nxt;
         pc_o_r   <= pc_o_nxt;
         pcb_o_r  <= pcb_o_nxt;
         sp_o_r   <= sp_o_nxt;
         fp_o_r   <= fp_o_nxt;
         ps_o_r   <= ps_o_nxt;
         rwe_r    <= rwe_nxt;
         rwd_r    <= rwd_nxt;
         mreq_r   <= mreq_nxt;
         mwr_r    <= mwr_nxt;
         mbyte_r  <= mbyte_nxt;
         maddr_r  <= maddr_nxt;
         mwdata_r <= mwdata_nxt;
      end
   end

   assign BUSY_O      = busy_r;
   assign DONE_O      = done_r;
   assign TAKEN_O     = tk_o_r;
   assign PC_O        = pc_o_r;
   assign PCB_O       = pcb_o_r;
   assign SP_O        = sp_o_r;
   assign FP_O        = fp_o_r;
   assign PS_O        = ps_o_r;
   assign REG_WE_O    = rwe_r;
   assign REG_WDATA_O = rwd_r;
   assign MEM_REQ_O   = mreq_r;
   assign MEM_WR_O    = mwr_r;
   assign MEM_BYTE_O  = mbyte_r;
   assign MEM_ADDR_O  = maddr_r;
   assign MEM_WDATA_O = mwdata_r;

endmodule

/* File: bench/clrc_exec_props.sv */
// Timing and flag checks for the execution sequencer
`timescale 1ns/100ps
module clrc_exec_props
   import clrc_pkg::*;
(
   input wire logic        REF_CLK_I,
   input wire logic        RSTN_I,
   input wire logic        START_I,
   input wire logic [3:0]  OP_I,
   input wire logic [15:0] OPND_I,
   input wire logic [15:0] IMM_I,
   input wire logic [15:0] PS_I,
   input wire logic        IRQ_PEND_I,
   input wire logic        BUSY_O,
   input wire logic        DONE_O,
   input wire logic        TAKEN_O,
   input wire logic [15:0] PS_O,
   input wire logic        MEM_REQ_O
);
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RSTN_I);
   sequence s_go(logic [3:0] op);
      START_I && !BUSY_O && OP_I == op;
   endsequence
   sequence s_bne;
      s_go(OP_CMPB_A) ##0 OPND_I[7:0] != IMM_I[7:0];
   endsequence
   a_start_busy: assert property (START_I && !BUSY_O |=> BUSY_O)
      else $error("busy not raised");
   a_done_pulse: assert property (DONE_O |=> !DONE_O)
      else $error("done longer than one cycle");
   a_bne_taken: assert property (s_bne |-> ##5 DONE_O && TAKEN_O)
      else $error("unequal byte compare wrong");
   a_beq_fall: assert property (s_go(OP_CMPB_A) ##0 OPND_I[7:0] == IMM_I[7:0]
      |-> ##4 DONE_O && !TAKEN_O)
      else $error("equal byte compare wrong");
   a_fast_nostack: assert property (s_go(OP_FAST_EXIT) ##0 IRQ_PEND_I
      |=> !MEM_REQ_O [*6])
      else $error("stack access on preempted exit");
   a_trap_flags: assert property (s_go(OP_TRAP_NINE) |-> ##[11:200]
      DONE_O && !PS_O[PS_I_BIT] && PS_O[PS_S_BIT])
      else $error("trap mode flags wrong");
   a_ret_flags: assert property (s_go(OP_SUB_WORD) |-> ##[4:40] DONE_O && PS_O == PS_I)
      else $error("return changed flags");
   a_dec_carry: assert property (s_go(OP_DECB) |-> ##[4:40]
      DONE_O && PS_O[PS_C_BIT] == PS_I[PS_C_BIT])
      else $error("decrement touched carry");
endmodule
bind clrc_exec clrc_exec_props i_clrc_exec_props (.*);

/* File: bench/clrc_exec_tb_top.sv */
// Self-checking bench for the execution sequencer
`timescale 1ns/100ps
module clrc_exec_tb_top
   import clrc_pkg::*;
;
   logic        REF_CLK_I = 1'b0, RSTN_I = 1'b0, START_I = 1'b0, MEM_FORM_I = 1'b0;
   logic        IRQ_PEND_I = 1'b0;
   logic [3:0]  OP_I = 4'h0, CORR_A_I = 4'h1, CORR_B_I = 4'h1, CORR_C_I = 4'h2, CORR_D_I = 4'h1;
   logic [7:0]  REL_I = 8'hfe, PCB_I = 8'h03, PCB_O;
   logic [15:0] OPND_I = '0, IMM_I = '0, EA_I = 16'h0200, PC_I = 16'h1000, SP_I = 16'h0800;
   logic [15:0] FP_I = 16'h0900, PS_I = '0, MEM_RDATA_I;
   logic [23:0] VECTOR_I = 24'h123456;
   logic        BUSY_O, DONE_O, TAKEN_O, REG_WE_O, MEM_REQ_O, MEM_WR_O, MEM_BYTE_O;
   logic [15:0] PC_O, SP_O, FP_O, PS_O, REG_WDATA_O, MEM_ADDR_O, MEM_WDATA_O;
   int          error_cnt = 0, checked = 0, n, nreq, nwr, nbyte, nwe;
   clrc_exec i_clrc_exec (.*);
   always #5 REF_CLK_I = ~REF_CLK_I;
   // Read data answers while the request stands, a fill pattern otherwise
   always_comb MEM_RDATA_I = MEM_REQ_O ? 16'h4a5c : 16'hb5a3;
   task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic run(input clrc_op_t op, input logic [15:0] a, b, ps, input logic irq);
      @(posedge REF_CLK_I);
      START_I    <= 1'b1;
      OP_I       <= op;
      OPND_I     <= a;
      IMM_I      <= b;
      PS_I       <= ps;
      IRQ_PEND_I <= irq;
      @(posedge REF_CLK_I);
      START_I <= 1'b0;
      n = 0;
      nreq = 0;
      nwr = 0;
      nbyte = 0;
      nwe = 0;
      forever begin
         @(negedge REF_CLK_I);
         nreq += MEM_REQ_O === 1'b1;
         nwr += MEM_WR_O === 1'b1;
         nbyte += MEM_BYTE_O === 1'b1;
         nwe += REG_WE_O === 1'b1;
         if (DONE_O === 1'b1 || n >= 300) break;
         n++;
      end
      chk("done", 24'h1, 24'(DONE_O));
   endtask
   task automatic t_cmp(input clrc_op_t op, input logic [15:0] a, b, input logic tk,
                        input logic [3:0] f, input logic [23:0] cyc);
      run(op, a, b, 16'h0000, 1'b0);
      chk("cycles", cyc, 24'(n));
      chk("taken", 24'(tk), 24'(TAKEN_O));
      chk("pc", tk ? 24'h000ffe : 24'h001000, 24'(PC_O));
      chk("flags", 24'(f), 24'(PS_O[3:0]));
      $display("compare case done");
   endtask
   task automatic t_dec;
      run(OP_DECB, 16'h0001, 16'h0000, 16'h0001, 1'b0);
      chk("dec cycles", 24'h4, 24'(n));
      chk("dec taken", 24'h0, 24'(TAKEN_O));
      chk("dec flags", 24'h5, 24'(PS_O[3:0]));
      chk("dec write", 24'h010000, {nwe[7:0], REG_WDATA_O});
      @(posedge REF_CLK_I) MEM_FORM_I <= 1'b1;
      run(OP_DECB, 16'h0002, 16'h0000, 16'h0000, 1'b0);
      @(posedge REF_CLK_I) MEM_FORM_I <= 1'b0;
      chk("mem dec cycles", 24'd9, 24'(n));
      chk("mem dec write", 24'h110200, {nwr[3:0], nbyte[3:0], MEM_ADDR_O});
      chk("mem dec data", 24'h000001, 24'(MEM_WDATA_O));
      $display("decrement done");
   endtask
   task automatic t_ret;
      run(OP_SUB_WORD, 16'h0000, 16'h0000, 16'h000f, 1'b0);
      chk("ret cycles", 24'h6, 24'(n));
      chk("ret pc", 24'h004a5c, 24'(PC_O));
      chk("ret sp", 24'h000802, 24'(SP_O));
      chk("ret read", 24'h010800, {nreq[7:0], MEM_ADDR_O});
      run(OP_SUB_FAR, 16'h0000, 16'h0000, 16'h000f, 1'b0);
      chk("far pc", 24'h5c4a5c, {PCB_O, PC_O});
      chk("far ps", 24'h00000f, 24'(PS_O));
      chk("far read", 24'h020802, {nreq[7:0], MEM_ADDR_O});
      $display("returns done");
   endtask
   task automatic t_exit;
      run(OP_FAST_EXIT, 16'h0000, 16'h0000, 16'h0003, 1'b1);
      chk("fast cycles", 24'd13, 24'(n));
      chk("fast target", 24'h123456, {PCB_O, PC_O});
      run(OP_TRAP_NINE, 16'h0000, 16'h0000, 16'h0040, 1'b0);
      chk("trap cycles", 24'd27, 24'(n));
      chk("trap flags", 24'h1, 24'(PS_O[6:5]));
      chk("trap pc", 24'h123456, {PCB_O, PC_O});
      chk("trap push", 24'h031000, {nwr[7:0], MEM_WDATA_O});
      run(OP_FRAME_TD, 16'h0000, 16'h0000, 16'h000f, 1'b0);
      chk("td fp", 24'h004a5c, 24'(FP_O));
      chk("td ps", 24'h00000f, 24'(PS_O));
      $display("exits done");
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge REF_CLK_I);
      RSTN_I <= 1'b1;
      t_cmp(OP_CMPB_A, 16'h0010, 16'h0020, 1'b1, 4'h9, 24'h4);
      t_cmp(OP_CMPB_A, 16'hab20, 16'h0020, 1'b0, 4'h4, 24'h3);
      t_cmp(OP_CMPW_A, 16'hab20, 16'h0020, 1'b1, 4'h8, 24'h4);
      t_cmp(OP_CMPW_EA, 16'h0005, 16'h0005, 1'b0, 4'h4, 24'h4);
      t_dec();
      t_ret();
      t_exit();
      finish_test();
   end
   initial begin
      #20000;
      error_cnt++;
      finish_test();
   end
endmodule
